// file: pump_code_loader.v
// Behaviour
// R1 - Pump loads default vectors and clears SRAM after any reset.
// R2 - Host starts a load writing 4Fh for control or 5Fh for DSP.
// R3 - Host waits until the pump copies the request code into 1Bh.
// R4 - Host writes start address low byte to 16h, then high byte to 17h.
// R5 - Pump aborts a stalled load after 30 seconds by zeroing the request.
// R6 - Host writes each byte only while the FIFO-not-full flag reads one.
// R7 - Pump updates 1Bh with buffer status; host paces on FIFO flag.
// R8 - After the last byte the host writes 00 into the request register.
// R9 - Host waits for FFh at 17h, then reads the checksum at 16h.
// R10 - On checksum mismatch the host resets the pump and reloads; the code only sets doneBad_r and leaves the reset and reload to software.
// R11 - Pump restores 1Bh after a load; 16h and 17h keep completion values.
// R12 - Pump waits 30 seconds for a new request between modules.
// R13 - Pump writes bytes where the host says, without module checks.
// R14 - Host avoids overlapping modules and keeps the vector table current.
// R15 - Pump requests a load when the selected mode's code is absent.
// R16 - Pump presets address to FFFFh and writes the needed module code.
// R17 - Pump requests a further module by writing its new code.
// R18 - Pump requests 43h, 4Ah, 48h or 40h after negotiation.
// R19 - Second variant requests 49h after configuration AAh unless preloaded.
// R20 - Client legacy mode sets configuration to 00h: reload both sections.
// R21 - Host loads each section's vector module last in the series.
// R22 - Checksum: rotate left one bit, add byte, modulo 256, from zero.
// R23 - Pump advances write address by one per accepted byte.
`include "pump_loader_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module pump_code_loader (
    input wire clk,
    input wire rstn,
    // Software port
    input wire [3:0] swAddr,
    input wire [31:0] swWdata,
    input wire swWr,
    input wire swRd,
    output reg [31:0] swRdata,
    // Pump interface memory port
    output reg [7:0] pumpAddr,
    output reg [7:0] pumpWdata,
    output reg pumpWrN,
    output reg pumpRdN,
    input wire [7:0] pumpRdata
);
    localparam [10:0] S_IDLE = 11'h001;
    localparam [10:0] S_REQ = 11'h002;
    localparam [10:0] S_ACK = 11'h004;
    localparam [10:0] S_ALO = 11'h008;
    localparam [10:0] S_AHI = 11'h010;
    localparam [10:0] S_FLAG = 11'h020;
    localparam [10:0] S_BYTE = 11'h040;
    localparam [10:0] S_END = 11'h080;
    localparam [10:0] S_DONE = 11'h100;
    localparam [10:0] S_SUM = 11'h200;
    localparam [10:0] S_WATCH = 11'h400;
    localparam [7:0] POLL_C = `POLL_CYC;

    // Expected checksum step, used to compare against the pump's result
    function [7:0] sumStep;
        input [7:0] acc;
        input [7:0] b;
        begin
            sumStep = {acc[6:0], acc[7]} + b; // R22
        end
    endfunction

    // True at the tick that ends a read slot this sequencer opened; outside
    // such a slot the released bus carries nothing worth sampling
    function readSlotEnd;
        input tick;
        input phase;
        input rdN;
        begin
            readSlotEnd = tick && phase && !rdN;
        end
    endfunction

    reg [10:0] state_r;
    reg [7:0] reqCode_r;
    reg [15:0] start_r;
    reg [7:0] data_r;
    reg dataValid_r;
    reg lastByte_r;
    reg [7:0] expSum_r;
    reg [7:0] pumpSum_r;
    reg [7:0] pumpReq_r;
    reg [15:0] nextAddr_r;
    reg busy_r;
    reg doneOk_r;
    reg doneBad_r;
    reg timedOut_r;
    reg serve_r;
    reg [7:0] poll_r;
    reg [31:0] wait_r;
    reg phase_r;
    reg [7:0] rdS1_r;
    reg [7:0] rdS2_r;

    wire pollTick = (poll_r == 8'h00);
    wire dataFree = !dataValid_r;
    wire rdDone = readSlotEnd(pollTick, phase_r, pumpRdN);
    wire loading = (state_r != S_IDLE) && (state_r != S_WATCH);
    wire byteOut = (state_r == S_BYTE) && pollTick && !phase_r;
    wire sumDone = (state_r == S_SUM) && rdDone;
    wire stalled = loading && (wait_r >= `WAIT_CYC);

    // Software writes
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            reqCode_r <= `REQ_NONE;
            start_r <= 16'h0000;
            data_r <= 8'h00;
            dataValid_r <= 1'b0;
            lastByte_r <= 1'b0;
            serve_r <= 1'b0;
        end else begin
            if (swWr && swAddr == `CR_CTRL && !busy_r) begin
                reqCode_r <= swWdata[`CTRL_DSP_BIT] ? `REQ_DSP : `REQ_CTL; // R2
                serve_r <= swWdata[`CTRL_SERVE_BIT];
            end
            if (swWr && swAddr == `CR_START)
                start_r <= swWdata[15:0];
            if (byteOut)
                dataValid_r <= 1'b0;
            else if (swWr && swAddr == `CR_DATA && dataFree) begin
                data_r <= swWdata[7:0];
                lastByte_r <= swWdata[8];
                dataValid_r <= 1'b1;
            end
            if (state_r == S_IDLE)
                dataValid_r <= 1'b0;
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn)
            swRdata <= 32'h0;
        else if (swRd) begin
            case (swAddr)
                `CR_STATUS: swRdata <= {26'h0, dataFree, serve_r, timedOut_r,
                    doneBad_r, doneOk_r, busy_r};
                `CR_RESULT: swRdata <= {16'h0, expSum_r, pumpSum_r};
                `CR_PUMPREQ: swRdata <= {24'h0, pumpReq_r};
                `CR_START: swRdata <= {16'h0, start_r};
                `CR_NEXT: swRdata <= {16'h0, nextAddr_r};
                default: swRdata <= 32'h0;
            endcase
        end else
            swRdata <= 32'h0;
    end

    // Pump data passes two stages since the pump is asynchronous to clk
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdS1_r <= 8'h00;
            rdS2_r <= 8'h00;
        end else begin
            rdS1_r <= pumpRdata;
            rdS2_r <= rdS1_r;
        end
    end

    wire goReq = swWr && swAddr == `CR_CTRL && swWdata[`CTRL_GO_BIT] && !busy_r;
    wire pumpNeeds = (rdS2_r != `REQ_NONE) && (rdS2_r != `REQ_CTL) && (rdS2_r != `REQ_DSP);

    // Stall counter: restarts with each load and each byte, so a host that
    // stops feeding bytes or a pump that never answers a poll can run it out
    always @(posedge clk or negedge rstn) begin
        if (!rstn)
            wait_r <= 32'h0;
        else if (goReq || byteOut)
            wait_r <= 32'h0;
        else if (loading)
            wait_r <= wait_r + 32'd1;
    end

    // Load bookkeeping, kept apart from the sequencer so that the results
    // seen by software change only at well defined points of a load
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            busy_r <= 1'b0;
            doneOk_r <= 1'b0;
            doneBad_r <= 1'b0;
            timedOut_r <= 1'b0;
            expSum_r <= 8'h00;
            pumpSum_r <= 8'h00;
            nextAddr_r <= 16'h0000;
        end else if (goReq) begin
            busy_r <= 1'b1;
            doneOk_r <= 1'b0;
            doneBad_r <= 1'b0;
            timedOut_r <= 1'b0;
            expSum_r <= 8'h00;
            nextAddr_r <= start_r; // R14 R21
        end else if (stalled) begin
            // Give up once the pump would have aborted anyway
            timedOut_r <= 1'b1; // R5
            busy_r <= 1'b0;
        end else if (byteOut) begin
            expSum_r <= sumStep(expSum_r, data_r); // R22
            nextAddr_r <= nextAddr_r + 16'h0001; // R23
        end else if (sumDone) begin
            pumpSum_r <= rdS2_r; // R9
            doneOk_r <= (rdS2_r == expSum_r);
            doneBad_r <= (rdS2_r != expSum_r); // R10
            busy_r <= 1'b0;
        end
    end

    // Pump access sequencer; each access holds its strobe for one poll
    // period, long enough for the pump's own sampling
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_r <= S_IDLE;
            pumpAddr <= 8'h00;
            pumpWdata <= 8'h00;
            pumpWrN <= 1'b1;
            pumpRdN <= 1'b1;
            poll_r <= 8'h00;
            phase_r <= 1'b0;
            pumpReq_r <= 8'h00;
        end else begin
            if (pollTick)
                poll_r <= POLL_C - 8'd1;
            else
                poll_r <= poll_r - 8'd1;
            if (pollTick) begin
                phase_r <= ~phase_r;
                pumpWrN <= 1'b1;
                pumpRdN <= 1'b1;
            end
            case (state_r)
                S_IDLE: if (serve_r && pollTick)
                    state_r <= S_WATCH;
                S_WATCH: if (pollTick) begin
                    if (!phase_r) begin
                        pumpAddr <= `PUMP_REQ_CODE;
                        pumpRdN <= 1'b0;
                    end else if (rdDone) begin
                        // The loader's own codes and zero are not requests
                        if (pumpNeeds)
                            pumpReq_r <= rdS2_r; // R16 R17
                        state_r <= S_IDLE;
                    end
                end
                S_REQ: if (pollTick && !phase_r) begin
                    pumpAddr <= `PUMP_REQ_CODE;
                    pumpWdata <= reqCode_r; // R2
                    pumpWrN <= 1'b0;
                    state_r <= S_ACK;
                end
                S_ACK: if (pollTick) begin
                    if (!phase_r) begin
                        pumpAddr <= `PUMP_ACK;
                        pumpRdN <= 1'b0;
                    end else if (rdDone && rdS2_r == reqCode_r)
                        state_r <= S_ALO; // R3
                end
                S_ALO: if (pollTick && !phase_r) begin
                    pumpAddr <= `PUMP_ADDR_LOW;
                    pumpWdata <= start_r[7:0]; // R4
                    pumpWrN <= 1'b0;
                    state_r <= S_AHI;
                end
                S_AHI: if (pollTick && !phase_r) begin
                    pumpAddr <= `PUMP_ADDR_HIGH;
                    pumpWdata <= start_r[15:8]; // R4
                    pumpWrN <= 1'b0;
                    state_r <= S_FLAG;
                end
                S_FLAG: if (pollTick) begin
                    // Pace on the FIFO flag, not on the 1Bh buffer status
                    if (!phase_r) begin
                        pumpAddr <= `PUMP_STATUS;
                        pumpRdN <= 1'b0;
                    end else if (rdDone && rdS2_r[`PUMP_TX_FIFO_NOT_FULL_BIT] && dataValid_r)
                        state_r <= S_BYTE; // R6 R7
                end
                S_BYTE: if (byteOut) begin
                    pumpAddr <= `PUMP_TXFIFO;
                    pumpWdata <= data_r;
                    pumpWrN <= 1'b0;
                    state_r <= lastByte_r ? S_END : S_FLAG;
                end
                S_END: if (pollTick && !phase_r) begin
                    pumpAddr <= `PUMP_REQ_CODE;
                    pumpWdata <= `REQ_NONE; // R8
                    pumpWrN <= 1'b0;
                    state_r <= S_DONE;
                end
                S_DONE: if (pollTick) begin
                    if (!phase_r) begin
                        pumpAddr <= `PUMP_ADDR_HIGH;
                        pumpRdN <= 1'b0;
                    end else if (rdDone && rdS2_r == `DONE_MARK)
                        state_r <= S_SUM; // R9
                end
                S_SUM: if (pollTick) begin
                    if (!phase_r) begin
                        pumpAddr <= `PUMP_ADDR_LOW;
                        pumpRdN <= 1'b0;
                    end else if (sumDone)
                        state_r <= S_IDLE; // R9
                end
                default: state_r <= S_IDLE;
            endcase
            // A load start wins over a pending watch read; that read slot
            // simply runs out unused
            if (goReq)
                state_r <= swWdata[`CTRL_SERVE_BIT] ? S_ALO : S_REQ;
            if (stalled)
                state_r <= S_IDLE; // R5
        end
    end
endmodule

`default_nettype wire

// file: pump_loader_defs.vh
`ifndef PUMP_LOADER_DEFS_VH
`define PUMP_LOADER_DEFS_VH

// Pump interface memory offsets
`define PUMP_REQ_CODE 8'h14
`define PUMP_ADDR_LOW 8'h16
`define PUMP_ADDR_HIGH 8'h17
`define PUMP_ACK 8'h1b
`define PUMP_STATUS 8'h0d
`define PUMP_TXFIFO 8'h10
`define PUMP_TX_FIFO_NOT_FULL_BIT 1

// Request codes, completion mark and address preset
`define REQ_CTL 8'h4f
`define REQ_DSP 8'h5f
`define REQ_NONE 8'h00
`define DONE_MARK 8'hff
`define PUMP_ADDR_PRESET 16'hffff

// Controller register offsets
`define CR_CTRL 4'h0
`define CR_START 4'h1
`define CR_STATUS 4'h2
`define CR_DATA 4'h3
`define CR_RESULT 4'h4
`define CR_PUMPREQ 4'h5
`define CR_NEXT 4'h6

// Control bits
`define CTRL_GO_BIT 0
`define CTRL_DSP_BIT 1
`define CTRL_SERVE_BIT 2

// Timing
`define CLK_NS 10
`define POLL_NS 200
`define POLL_CYC 8'd20
`define WAIT_S 30
`define WAIT_CYC 32'd3000000000

`endif

// file: pump_code_loader_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module pump_code_loader_monitor (
    input wire clk,
    input wire rstn,
    input wire [3:0] swAddr,
    input wire [31:0] swWdata,
    input wire swWr,
    input wire swRd,
    input wire [31:0] swRdata,
    input wire [7:0] pumpAddr,
    input wire [7:0] pumpWdata,
    input wire pumpWrN,
    input wire pumpRdN,
    input wire [7:0] pumpRdata
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    logic [7:0] lastWr;
    logic fnf, done;
    logic [4:0] lowCnt;
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            lastWr <= 8'h00;
            fnf <= 1'b0;
            done <= 1'b0;
            lowCnt <= 5'h00;
        end else begin
            lowCnt <= pumpWrN ? 5'h00 : lowCnt + 5'h01;
            if (!pumpRdN && pumpAddr == 8'h0d)
                fnf <= pumpRdata[1];
            if (!pumpRdN && pumpAddr == 8'h17)
                done <= pumpRdata == 8'hff;
            if ($fell(pumpWrN))
                lastWr <= pumpAddr;
            // Each byte needs its own fresh look at the flag
            if ($fell(pumpWrN) && pumpAddr == 8'h10)
                fnf <= 1'b0;
        end
    end
    sequence s_wr_go;
        $fell(pumpWrN);
    endsequence
    sequence s_rd_go;
        $fell(pumpRdN);
    endsequence
    property p_rd_slot;
        !$past(swRd) |-> swRdata == 32'h0;
    endproperty
    a_rd_slot: assert property (p_rd_slot) else $error("read data off slot");
    property p_one_strobe;
        pumpWrN || pumpRdN;
    endproperty
    a_one_strobe: assert property (p_one_strobe) else $error("both strobes low");
    property p_wr_hold;
        s_wr_go |=> (!pumpWrN && $stable(pumpAddr) && $stable(pumpWdata)) [*8];
    endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("write not held");
    property p_wr_len;
        $rose(pumpWrN) |-> lowCnt == 5'd20;
    endproperty
    a_wr_len: assert property (p_wr_len) else $error("write length");
    property p_req_code;
        s_wr_go ##0 pumpAddr == 8'h14 |-> pumpWdata inside {8'h4f, 8'h5f, 8'h00};
    endproperty
    a_req_code: assert property (p_req_code) else $error("bad code");
    property p_addr_order;
        s_wr_go ##0 pumpAddr == 8'h17 |-> lastWr == 8'h16;
    endproperty
    a_addr_order: assert property (p_addr_order) else $error("high first");
    property p_fnf_gate;
        s_wr_go ##0 pumpAddr == 8'h10 |-> fnf;
    endproperty
    a_fnf_gate: assert property (p_fnf_gate) else $error("byte unpaced");
    property p_done_gate;
        s_rd_go ##0 pumpAddr == 8'h16 |-> done;
    endproperty
    a_done_gate: assert property (p_done_gate) else $error("early crc");
endmodule
bind pump_code_loader pump_code_loader_monitor pump_code_loader_monitor_inst (
    .clk(clk), .rstn(rstn), .swAddr(swAddr), .swWdata(swWdata), .swWr(swWr), .swRd(swRd),
    .swRdata(swRdata), .pumpAddr(pumpAddr), .pumpWdata(pumpWdata), .pumpWrN(pumpWrN),
    .pumpRdN(pumpRdN), .pumpRdata(pumpRdata));
`default_nettype wire

// file: pump_model.sv
`timescale 1ns/1ps
`default_nettype none
module pump_model #(parameter int TMO = 200000) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wrN,
    input wire logic rdN,
    output logic [7:0] rdata
);
    logic [7:0] sp [0:31];
    logic [7:0] sram [0:255];
    logic [7:0] crc, saved;
    logic [7:0] last = 8'h00;
    logic [15:0] ptr;
    logic [5:0] fill;
    logic wrQ, act;
    int idle;
    // Released bus shows a flipped value so a late sample cannot pass
    assign rdata = rdN ? ~last : addr == 8'h0d ? {6'h0, fill == 6'h0, 1'b0} : sp[addr[4:0]];
    always @(posedge clk)
        if (!rdN)
            last <= rdata;
    task automatic request(input logic [7:0] code);
        sp[8'h16] = 8'hff;
        sp[8'h17] = 8'hff;
        ptr = 16'hffff;
        saved = sp[8'h1b];
        sp[8'h14] = code;
        act = 1'b1;
        crc = 8'h00;
    endtask
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < 256; i++)
                sram[i] <= 8'h00;
            for (int i = 0; i < 32; i++)
                sp[i] <= 8'h00;
            {ptr, crc, saved, fill, act, idle} <= '0;
            wrQ <= 1'b1;
        end else begin
            wrQ <= wrN;
            fill <= fill - {5'h0, fill != 6'h0};
            idle <= idle + 1;
            if (!wrN && wrQ) begin
                idle <= 0;
                case (addr)
                    8'h14: begin
                        sp[8'h14] <= wdata;
                        if (wdata != 8'h00) begin
                            saved <= sp[8'h1b];
                            sp[8'h1b] <= wdata;
                            crc <= 8'h00;
                            act <= 1'b1;
                        end else if (act) begin
                            sp[8'h17] <= 8'hff;
                            sp[8'h16] <= crc;
                            sp[8'h1b] <= saved;
                            act <= 1'b0;
                        end
                    end
                    8'h16: ptr[7:0] <= wdata;
                    8'h17: ptr[15:8] <= wdata;
                    8'h10: begin
                        sram[ptr[7:0]] <= wdata;
                        ptr <= ptr + 16'h1;
                        crc <= {crc[6:0], crc[7]} + wdata;
                        sp[8'h1b] <= ptr[7:0];
                        fill <= 6'd40;
                    end
                    default: ;
                endcase
            end
            if (act && idle == TMO) begin
                sp[8'h14] <= 8'h00;
                act <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// file: pump_code_ram_download_test.sv
`timescale 1ns/1ps
`default_nettype none
module pump_code_ram_download_test;
    logic clk = 1'b0, rstn = 1'b0, swWr = 1'b0, swRd = 1'b0, pWrN, pRdN;
    logic [3:0] swAddr = 4'h0;
    logic [31:0] swWdata = 32'h0, swRdata, v;
    logic [7:0] pAddr, pWdata, pRdata;
    logic [7:0] codes [5] = '{8'h43, 8'h4a, 8'h48, 8'h40, 8'h49};
    int n_errors = 0, samples_checked = 0;
    always #5 clk = ~clk;
    pump_code_loader pump_code_loader_inst (.clk(clk), .rstn(rstn), .swAddr(swAddr),
        .swWdata(swWdata), .swWr(swWr), .swRd(swRd), .swRdata(swRdata), .pumpAddr(pAddr),
        .pumpWdata(pWdata), .pumpWrN(pWrN), .pumpRdN(pRdN), .pumpRdata(pRdata));
    pump_model pump_model_inst (.clk(clk), .rstn(rstn), .addr(pAddr), .wdata(pWdata),
        .wrN(pWrN), .rdN(pRdN), .rdata(pRdata));
    task test_done;
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task check(input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            n_errors++;
            $display("Error %0t: saw %h want %h", $time, s, e);
        end
    endtask
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        swAddr <= a;
        swWdata <= d;
        swWr <= 1'b1;
        @(posedge clk);
        swWr <= 1'b0;
    endtask
    task rd(input logic [3:0] a);
        @(posedge clk);
        swAddr <= a;
        swRd <= 1'b1;
        @(posedge clk);
        swRd <= 1'b0;
        @(negedge clk);
        v = swRdata;
    endtask
    task poll(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
        for (int i = 0; i < 5000; i++) begin
            rd(a);
            if ((v & m) === e)
                return;
        end
        check(v & m, e);
    endtask
    task load(input logic [2:0] ctl, input logic [15:0] st, input int n);
        logic [7:0] c;
        c = 8'h00;
        wr(4'h1, {16'h0, st});
        wr(4'h0, {29'h0, ctl});
        for (int i = 0; i < n; i++) begin
            c = {c[6:0], c[7]} + (st[7:0] ^ 8'(i * 29));
            poll(4'h2, 32'h20, 32'h20);
            wr(4'h3, {23'h0, i == n - 1, st[7:0] ^ 8'(i * 29)});
        end
        poll(4'h2, 32'h1, 32'h0);
        check(v[2:1], 2'b01);
        rd(4'h4);
        check(v[7:0], c);
        check(v[15:8], c);
        rd(4'h6);
        check(v, {16'h0, st + 16'(n)});
        check(pump_model_inst.sp[8'h14], 8'h00);
        for (int i = 0; i < n; i++)
            check(pump_model_inst.sram[8'(st + i)], st[7:0] ^ 8'(i * 29));
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        rd(4'h2);
        check(v[0], 1'b0);
        load(3'b001, 16'h1400, 3);
        // Low byte wraps mid-module
        load(3'b011, 16'h30fe, 4);
        wr(4'h0, 32'h4);
        for (int k = 0; k < 5; k++) begin
            @(negedge clk);
            pump_model_inst.request(codes[k]);
            poll(4'h5, 32'hff, {24'h0, codes[k]});
        end
        load(3'b101, 16'h0100, 2);
        test_done;
    end
    initial begin
        #900000;
        n_errors++;
        test_done;
    end
endmodule
`default_nettype wire
